// ### logic/prf_phy_register_file.sv
// APB-reached paged register file of a three-port serial bus PHY
module prf_phy_register_file #(
  parameter int unsigned ADDR_W    = prf_pkg::PRF_ADDR_W,
  parameter int unsigned NUM_PORTS = prf_pkg::PRF_NUM_PORTS
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [5:0]              phys_id,
  input  wire logic                    root_node,
  input  wire logic                    cps_pin,
  input  wire logic                    blink_status,
  input  wire logic                    bus_reset,
  input  wire logic                    cfg_valid,
  input  wire logic [5:0]              cfg_gap,
  input  wire logic                    cfg_rhb,
  input  wire logic [NUM_PORTS*64-1:0] port_page_data,
  output logic                         root_holdoff,
  output logic                         long_reset_req,
  output logic                         short_reset_req,
  output logic [5:0]                   gap_count,
  output logic                         standby_enable,
  output logic                         link_ctrl,
  output logic                         contender,
  output logic [2:0]                   pwr_class,
  output logic [7:0]                   int_feature,
  output logic [2:0]                   max_legacy_spd,
  output logic [1:0]                   bridge_mode,
  output logic [2:0]                   page_sel,
  output logic [3:0]                   port_sel,
  output logic                         page_wr,
  output logic [3:0]                   page_wr_port,
  output logic [2:0]                   page_wr_index,
  output logic [7:0]                   page_wr_data
);
  import prf_pkg::*;

  typedef struct packed {
    logic [7:0][7:0] base;
    logic [1:0]      cps_sync;
    logic            reset_seen;
    logic [31:0]     rdata;
    logic            slverr;
    logic            pg_wr;
    logic [3:0]      pg_port;
    logic [2:0]      pg_index;
    logic [7:0]      pg_data;
  } prf_state_t;

  prf_state_t s;
  prf_state_t next_s;

  // Word index of a byte address
  function automatic logic [3:0] prf_reg_index(input logic [ADDR_W-1:0] addr);
    prf_reg_index = addr[5:2];
  endfunction : prf_reg_index

  // Aligned and inside the sixteen words
  function automatic logic prf_addr_hit(input logic [ADDR_W-1:0] addr);
    prf_addr_hit = (addr[1:0] == 2'b00) && ((addr >> 6) == '0);
  endfunction : prf_addr_hit

  // Only the writable bits take the new value
  function automatic logic [7:0] prf_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] mask);
    prf_merge = (old_v & ~mask) | (new_v & mask);
  endfunction : prf_merge

  logic [3:0] idx;
  logic       hit;
  logic       setup;
  logic       wr_take;
  logic [2:0] cur_page;
  logic [3:0] cur_port;
  logic [7:0] ro_byte;
  logic [7:0] base_byte;
  logic [7:0] paged_byte;
  logic [7:0] rd_byte;
  logic       paged_wr;

  assign idx      = prf_reg_index(paddr);
  assign hit      = prf_addr_hit(paddr);
  assign setup    = psel && !penable;
  // Byte lane 0 carries the register; a write without it is dropped
  assign wr_take  = psel && penable && pwrite && hit && pstrb[0];
  assign cur_page = s.base[PRF_IDX_PAGE_PORT[2:0]][PRF_PAGE_LSB +: 3];
  assign cur_port = s.base[PRF_IDX_PAGE_PORT[2:0]][PRF_PORT_LSB +: 4];
  assign paged_wr = wr_take && (idx >= PRF_IDX_PAGED_FIRST);

  // Read-only fields, composed from live state and fixed values; reserved bits stay zero
  always_comb begin
    ro_byte = 8'h00;
    case (idx)
      PRF_IDX_NODE_ID: begin
        ro_byte[PRF_PHYS_ID_LSB +: 6] = phys_id;
        ro_byte[PRF_ROOT_BIT]         = root_node;
        ro_byte[PRF_CPS_BIT]          = s.cps_sync[1];
      end
      PRF_IDX_PORT_COUNT: begin
        ro_byte[PRF_EXT_LSB +: 3]    = PRF_EXTENDED;
        ro_byte[PRF_NPORTS_LSB +: 4] = PRF_NPORTS_VALUE;
      end
      PRF_IDX_SPEED_DELAY: begin
        ro_byte[PRF_SPEED_LSB +: 3] = PRF_PHY_SPEED;
        ro_byte[PRF_DELAY_LSB +: 4] = PRF_DELAY_VALUE;
      end
      PRF_IDX_LINK_POWER: begin
        ro_byte[PRF_JITTER_LSB +: 3] = PRF_JITTER_VALUE;
      end
      PRF_IDX_LEGACY: begin
        ro_byte[PRF_BLINK_BIT] = blink_status;
      end
      default: begin
        ro_byte = 8'h00;
      end
    endcase
  end

  // Base bytes never look at the page field
  assign base_byte = (s.base[idx[2:0]] & PRF_WMASK[idx[2:0]]) | ro_byte;
  assign rd_byte   = idx[3] ? paged_byte : base_byte;

  prf_page_bank #(
    .NUM_PORTS      (NUM_PORTS)
  ) u_bank (
    .pclk           (pclk),
    .presetn        (presetn),
    .page           (cur_page),
    .port           (cur_port),
    .index          (idx[2:0]),
    .wr_en          (paged_wr),
    .wr_data        (pwdata[7:0]),
    .port_page_data (port_page_data),
    .rd_data        (paged_byte)
  );

  always_comb begin
    next_s          = s;
    next_s.cps_sync = {s.cps_sync[0], cps_pin};
    next_s.pg_wr    = 1'b0;

    // Answer is prepared in the setup cycle and held through the access
    if (setup) begin
      next_s.slverr = !hit;
      next_s.rdata  = hit ? {24'h000000, rd_byte} : 32'h00000000;
    end

    // Bus reset ends any pending reset request
    if (bus_reset) begin
      next_s.base[PRF_IDX_ROOT_GAP[2:0]][PRF_IBR_BIT]     = 1'b0;
      next_s.base[PRF_IDX_INT_FEATURE[2:0]][PRF_ISBR_BIT] = 1'b0;
      // Second bus reset without a gap write restores the default gap
      if (s.reset_seen) begin
        next_s.base[PRF_IDX_ROOT_GAP[2:0]][PRF_GAP_LSB +: 6] = PRF_GAP_RESET;
      end
      next_s.reset_seen = 1'b1;
    end

    // Configuration packet from the cable side
    if (cfg_valid) begin
      next_s.base[PRF_IDX_ROOT_GAP[2:0]][PRF_GAP_LSB +: 6] = cfg_gap;
      next_s.base[PRF_IDX_ROOT_GAP[2:0]][PRF_RHB_BIT]      = cfg_rhb;
      next_s.reset_seen                                    = 1'b0;
    end

    // Software write comes last so that a set beats a same-cycle clear
    if (wr_take) begin
      if (!idx[3]) begin
        next_s.base[idx[2:0]] = prf_merge(s.base[idx[2:0]], pwdata[7:0], PRF_WMASK[idx[2:0]]);
        if (idx == PRF_IDX_ROOT_GAP) begin
          next_s.reset_seen = 1'b0;
        end
      end else if (cur_page == PRF_PAGE_PORT_STATUS && 32'(cur_port) < NUM_PORTS) begin
        next_s.pg_wr    = 1'b1;
        next_s.pg_port  = cur_port;
        next_s.pg_index = idx[2:0];
        next_s.pg_data  = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s      <= '0;
      s.base <= PRF_BASE_RST;
    end else begin
      s <= next_s;
    end
  end

  // Zero wait states: every access phase completes at its first edge
  assign pready  = 1'b1;
  assign prdata  = s.rdata;
  assign pslverr = s.slverr;

  assign root_holdoff    = s.base[PRF_IDX_ROOT_GAP[2:0]][PRF_RHB_BIT];
  assign long_reset_req  = s.base[PRF_IDX_ROOT_GAP[2:0]][PRF_IBR_BIT];
  assign gap_count       = s.base[PRF_IDX_ROOT_GAP[2:0]][PRF_GAP_LSB +: 6];
  assign standby_enable  = s.base[PRF_IDX_SPEED_DELAY[2:0]][PRF_SREN_BIT];
  assign link_ctrl       = s.base[PRF_IDX_LINK_POWER[2:0]][PRF_LCTRL_BIT];
  assign contender       = s.base[PRF_IDX_LINK_POWER[2:0]][PRF_CONTEND_BIT];
  assign pwr_class       = s.base[PRF_IDX_LINK_POWER[2:0]][PRF_PWR_LSB +: 3];
  assign int_feature     = s.base[PRF_IDX_INT_FEATURE[2:0]];
  assign short_reset_req = s.base[PRF_IDX_INT_FEATURE[2:0]][PRF_ISBR_BIT];
  assign max_legacy_spd  = s.base[PRF_IDX_LEGACY[2:0]][PRF_LEGACY_LSB +: 3];
  assign bridge_mode     = s.base[PRF_IDX_LEGACY[2:0]][PRF_BRIDGE_LSB +: 2];
  assign page_sel        = cur_page;
  assign port_sel        = cur_port;
  assign page_wr         = s.pg_wr;
  assign page_wr_port    = s.pg_port;
  assign page_wr_index   = s.pg_index;
  assign page_wr_data    = s.pg_data;

endmodule : prf_phy_register_file

// ### logic/prf_pkg.sv
// Package: register map, field layout and constants of the paged PHY register file
//
// Notes on behaviour
// - Sixteen byte registers, selected by a four-bit register index 0 to 15.
// - Indices 0 to 7 are fixed base registers whatever page is selected.
// - Indices 8 to 15 show one of eight pages, numbered 0 to 7.
// - Active page comes from the page field of base register 7, following writes.
// - Base register fields and contents never depend on the selected page.
// - Reserved registers and reserved bit fields always read back as zero.
// - With pages 2 to 6 selected, every paged register reads zero.
package prf_pkg;

  // Bus geometry: each byte register takes one aligned 32-bit word
  localparam int unsigned PRF_ADDR_W    = 8;
  localparam int unsigned PRF_DATA_W    = 32;
  localparam int unsigned PRF_NUM_REGS  = 16;
  localparam int unsigned PRF_NUM_PORTS = 3;
  localparam int unsigned PRF_PAGE_BYTES = 8;

  // Register indices; byte address is four times the index
  localparam logic [3:0] PRF_IDX_NODE_ID     = 4'h0;
  localparam logic [3:0] PRF_IDX_ROOT_GAP    = 4'h1;
  localparam logic [3:0] PRF_IDX_PORT_COUNT  = 4'h2;
  localparam logic [3:0] PRF_IDX_SPEED_DELAY = 4'h3;
  localparam logic [3:0] PRF_IDX_LINK_POWER  = 4'h4;
  localparam logic [3:0] PRF_IDX_INT_FEATURE = 4'h5;
  localparam logic [3:0] PRF_IDX_LEGACY      = 4'h6;
  localparam logic [3:0] PRF_IDX_PAGE_PORT   = 4'h7;
  localparam logic [3:0] PRF_IDX_PAGED_FIRST = 4'h8;

  // Page numbers
  localparam logic [2:0] PRF_PAGE_PORT_STATUS = 3'h0;
  localparam logic [2:0] PRF_PAGE_VENDOR_ID   = 3'h1;
  localparam logic [2:0] PRF_PAGE_VENDOR_DEP  = 3'h7;

  // Field positions (bit 7 is the first bit on the wire)
  localparam int unsigned PRF_PHYS_ID_LSB = 2;
  localparam int unsigned PRF_ROOT_BIT    = 1;
  localparam int unsigned PRF_CPS_BIT     = 0;
  localparam int unsigned PRF_RHB_BIT     = 7;
  localparam int unsigned PRF_IBR_BIT     = 6;
  localparam int unsigned PRF_GAP_LSB     = 0;
  localparam int unsigned PRF_EXT_LSB     = 5;
  localparam int unsigned PRF_NPORTS_LSB  = 0;
  localparam int unsigned PRF_SPEED_LSB   = 5;
  localparam int unsigned PRF_SREN_BIT    = 4;
  localparam int unsigned PRF_DELAY_LSB   = 0;
  localparam int unsigned PRF_LCTRL_BIT   = 7;
  localparam int unsigned PRF_CONTEND_BIT = 6;
  localparam int unsigned PRF_JITTER_LSB  = 3;
  localparam int unsigned PRF_PWR_LSB     = 0;
  localparam int unsigned PRF_ISBR_BIT    = 6;
  localparam int unsigned PRF_LEGACY_LSB  = 5;
  localparam int unsigned PRF_BLINK_BIT   = 4;
  localparam int unsigned PRF_BRIDGE_LSB  = 2;
  localparam int unsigned PRF_PAGE_LSB    = 5;
  localparam int unsigned PRF_PORT_LSB    = 0;

  // Fixed read-only field values
  localparam logic [2:0] PRF_EXTENDED     = 3'h7;
  localparam logic [3:0] PRF_NPORTS_VALUE = 4'h3;
  localparam logic [2:0] PRF_PHY_SPEED    = 3'h7;
  localparam logic [3:0] PRF_DELAY_VALUE  = 4'hf;
  localparam logic [2:0] PRF_JITTER_VALUE = 3'h0;

  // Writable bits of base registers 7..0; all others are read-only or reserved
  localparam logic [7:0][7:0] PRF_WMASK =
    {8'hef, 8'hec, 8'hff, 8'hc7, 8'h10, 8'h00, 8'hff, 8'h00};

  // Reset values of base registers 7..0
  localparam logic [7:0][7:0] PRF_BASE_RST =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00};
  localparam logic [5:0] PRF_GAP_RESET = 6'h3f;

  // Identification page bytes 7..0; values are arbitrary
  localparam logic [7:0][7:0] PRF_VENDOR_PAGE =
    {8'h00, 8'h00, 8'h01, 8'h5a, 8'h5a, 8'h00, 8'h00, 8'h01};

endpackage : prf_pkg

// ### logic/prf_page_bank.sv
// Paged register bank: port status, identification and scratch pages
module prf_page_bank #(
  parameter int unsigned NUM_PORTS = prf_pkg::PRF_NUM_PORTS
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [2:0]                page,
  input  wire logic [3:0]                port,
  input  wire logic [2:0]                index,
  input  wire logic                      wr_en,
  input  wire logic [7:0]                wr_data,
  input  wire logic [NUM_PORTS*64-1:0]   port_page_data,
  output logic      [7:0]                rd_data
);
  import prf_pkg::*;

  typedef struct packed {
    logic [PRF_PAGE_BYTES-1:0][7:0] scratch;
  } prf_bank_t;

  prf_bank_t s;
  prf_bank_t next_s;

  always_comb begin
    next_s = s;
    // Only the vendor scratch page holds writable storage
    if (wr_en && page == PRF_PAGE_VENDOR_DEP) begin
      next_s.scratch[index] = wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    rd_data = 8'h00;
    case (page)
      PRF_PAGE_PORT_STATUS: begin
        // Unimplemented ports behave as reserved
        if (32'(port) < NUM_PORTS) begin
          rd_data = port_page_data[(32'(port) * PRF_PAGE_BYTES + 32'(index)) * 8 +: 8];
        end
      end
      PRF_PAGE_VENDOR_ID: begin
        rd_data = PRF_VENDOR_PAGE[index];
      end
      PRF_PAGE_VENDOR_DEP: begin
        rd_data = s.scratch[index];
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

endmodule : prf_page_bank

// ### sim/prf_core_model.sv
// Far-side model: per-port status bytes and node status lines
module prf_core_model (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                page_wr,
  input  wire logic [3:0]                          page_wr_port,
  input  wire logic [2:0]                          page_wr_index,
  input  wire logic [7:0]                          page_wr_data,
  output logic      [5:0]                          phys_id,
  output logic                                     root_node,
  output logic                                     cps_pin,
  output logic                                     blink_status,
  output logic      [prf_pkg::PRF_NUM_PORTS*64-1:0] port_page_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import prf_pkg::*;
  assign phys_id = 6'h2d;
  assign root_node = 1'b1;
  assign cps_pin = 1'b1;
  assign blink_status = 1'b1;
  // Distinct byte per slot so a wrong port or index shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PRF_NUM_PORTS * 8; i++) port_page_data[i*8 +: 8] <= 8'(i) ^ 8'ha0;
    end else if (page_wr && page_wr_port < PRF_NUM_PORTS) begin
      port_page_data[(page_wr_port * 8 + page_wr_index) * 8 +: 8] <= page_wr_data;
    end
  end
endmodule : prf_core_model

// ### sim/prf_monitor.sv
// Port-level assertions of the paged register file
module prf_monitor #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [5:0]        phys_id,
  input wire logic              root_node,
  input wire logic [2:0]        page_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic rd_setup = psel && !penable && !pwrite;
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_upper; rd_setup |=> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_range; rd_setup && paddr >= 8'h40 |=> pslverr && prdata == 32'h0; endproperty
  a_range: assert property (p_range) else $error("unmapped read not refused");
  property p_id; rd_setup && paddr == 8'h00 |=> prdata[7:1] == {$past(phys_id), $past(root_node)}; endproperty
  a_id: assert property (p_id) else $error("status register wrong");
  property p_ports; rd_setup && paddr == 8'h08 |=> prdata == 32'he3; endproperty
  a_ports: assert property (p_ports) else $error("port count register wrong");
  property p_speed; rd_setup && paddr == 8'h0c |=> (prdata & 32'hffffffef) == 32'hef; endproperty
  a_speed: assert property (p_speed) else $error("speed register wrong");
  property p_rsvd; rd_setup && paddr == 8'h18 |=> prdata[1:0] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved field nonzero");
  property p_page; psel && penable && pwrite && paddr == 8'h1c && pstrb[0] |=> page_sel == $past(pwdata[7:5]);
  endproperty
  a_page: assert property (p_page) else $error("page choice not taken");
  property p_void; rd_setup && paddr[7:5] == 3'h1 && page_sel inside {[3'h2:3'h6]} |=> prdata == 32'h0; endproperty
  a_void: assert property (p_void) else $error("reserved page nonzero");
  property p_ident; rd_setup && paddr == 8'h20 && page_sel == 3'h1 |=> prdata == 32'h01; endproperty
  a_ident: assert property (p_ident) else $error("identification byte wrong");
endmodule : prf_monitor

bind prf_phy_register_file prf_monitor #(.ADDR_W(ADDR_W)) u_prf_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phys_id(phys_id), .root_node(root_node), .page_sel(page_sel)
);

// ### sim/tb_prf_phy_register_file.sv
// Testbench: APB register tests of the paged register file
module tb_prf_phy_register_file;
  timeunit 1ns;
  timeprecision 1ps;
  import prf_pkg::*;
  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [5:0]    phys_id;
  logic          root_node;
  logic          cps_pin;
  logic          blink_status;
  logic [191:0]  port_page_data;
  logic          page_wr;
  logic [3:0]    page_wr_port;
  logic [2:0]    page_wr_index;
  logic [7:0]    page_wr_data;
  logic          bus_reset;
  logic          cfg_valid;
  logic [5:0]    cfg_gap;
  logic          cfg_rhb;
  logic          root_holdoff;
  logic          long_reset_req;
  logic          short_reset_req;
  logic [5:0]    gap_count;
  logic          standby_enable;
  logic          link_ctrl;
  logic          contender;
  logic [2:0]    pwr_class;
  logic [7:0]    int_feature;
  logic [2:0]    max_legacy_spd;
  logic [1:0]    bridge_mode;
  logic [3:0]    port_sel;
  logic [31:0]   d;
  logic          e;
  int            errors;
  int            n_checks;

  prf_phy_register_file u_prf_phy_register_file (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phys_id(phys_id), .root_node(root_node), .cps_pin(cps_pin), .blink_status(blink_status),
    .bus_reset(bus_reset), .cfg_valid(cfg_valid), .cfg_gap(cfg_gap), .cfg_rhb(cfg_rhb),
    .port_page_data(port_page_data), .root_holdoff(root_holdoff), .long_reset_req(long_reset_req),
    .short_reset_req(short_reset_req), .gap_count(gap_count), .standby_enable(standby_enable),
    .link_ctrl(link_ctrl), .contender(contender), .pwr_class(pwr_class), .int_feature(int_feature),
    .max_legacy_spd(max_legacy_spd), .bridge_mode(bridge_mode), .page_sel(), .port_sel(port_sel),
    .page_wr(page_wr), .page_wr_port(page_wr_port), .page_wr_index(page_wr_index), .page_wr_data(page_wr_data)
  );
  prf_core_model u_prf_core_model (
    .pclk(pclk), .presetn(presetn), .page_wr(page_wr), .page_wr_port(page_wr_port),
    .page_wr_index(page_wr_index), .page_wr_data(page_wr_data), .phys_id(phys_id), .root_node(root_node),
    .cps_pin(cps_pin), .blink_status(blink_status), .port_page_data(port_page_data)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Held from setup until pready is seen high; one idle cycle after
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    xfer(1'b1, a, wd);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(d, exp);
    chk({31'h0, e}, 32'h0);
  endtask : rdc

  // One-cycle pulse of the core-side strobes, then one settled cycle
  task automatic pulse(input logic br, input logic cv);
    bus_reset <= br;
    cfg_valid <= cv;
    @(posedge pclk);
    bus_reset <= 1'b0;
    cfg_valid <= 1'b0;
    @(posedge pclk);
  endtask : pulse

  // Control outputs packed into one word for a single compare
  function automatic logic [31:0] outs();
    outs = {root_holdoff, long_reset_req, short_reset_req, standby_enable, link_ctrl, contender,
            gap_count, pwr_class, int_feature, max_legacy_spd, bridge_mode, port_sel};
  endfunction : outs

  function automatic logic [31:0] pg_exp(input logic [2:0] p);
    case (p)
      3'h0: pg_exp = 32'ha8;
      3'h1: pg_exp = {24'h0, PRF_VENDOR_PAGE[0]};
      3'h7: pg_exp = 32'h5a;
      default: pg_exp = 32'h0;
    endcase
  endfunction : pg_exp

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bus_reset = 1'b0;
    cfg_valid = 1'b0;
    cfg_gap = 6'h12;
    cfg_rhb = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(8'h04, 32'h3f);
    wr(8'h08, 8'hff);
    rdc(8'h08, 32'he3);
    rdc(8'h0c, 32'hef);
    rdc(8'h00, 32'hb7);
    wr(8'h18, 8'hff);
    rdc(8'h18, 32'hfc);
    wr(8'h1c, 8'hff);
    rdc(8'h1c, 32'hef);
    wr(8'h20, 8'h5a);
    // Page 7 last, so stray writes in pages 1..6 would show there
    for (int p = 0; p < 8; p++) begin
      wr(8'h1c, {p[2:0], 5'h01});
      if (p inside {[1:6]}) wr(8'h20, 8'hff);
      rdc(8'h20, pg_exp(p[2:0]));
      rdc(8'h04, 32'h3f);
    end
    wr(8'h1c, 8'h01);
    wr(8'h24, 8'h3c);
    rdc(8'h24, 32'h3c);
    chk(outs(), {6'b000000, 6'h3f, 3'h0, 8'h00, 3'h7, 2'h3, 4'h1});
    wr(8'h04, 8'hff);
    wr(8'h0c, 8'hff);
    wr(8'h10, 8'hff);
    wr(8'h14, 8'hff);
    chk(outs(), {6'b111111, 6'h3f, 3'h7, 8'hff, 3'h7, 2'h3, 4'h1});
    rdc(8'h0c, 32'hff);
    rdc(8'h10, 32'hc7);
    pulse(1'b0, 1'b1);
    chk(outs(), {6'b011111, 6'h12, 3'h7, 8'hff, 3'h7, 2'h3, 4'h1});
    pulse(1'b1, 1'b0);
    chk(outs(), {6'b000111, 6'h12, 3'h7, 8'hbf, 3'h7, 2'h3, 4'h1});
    // Second bus reset with no gap write in between restores the default gap
    pulse(1'b1, 1'b0);
    chk(outs(), {6'b000111, 6'h3f, 3'h7, 8'hbf, 3'h7, 2'h3, 4'h1});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(outs(), {6'b000000, 6'h3f, 3'h0, 8'h00, 3'h0, 2'h0, 4'h0});
    rdc(8'h04, 32'h3f);
    xfer(1'b0, 8'h40, 8'h00);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    close_out();
  end

  initial begin
    #20000;
    errors++;
    close_out();
  end
endmodule : tb_prf_phy_register_file
